//--- fec_pkg.sv
// Package with constants, types and register map of the frame classifier
`default_nettype none
package fec_pkg;
    typedef enum logic [2:0] {
        CLS_UNVOICED,
        CLS_UV_TRANS,
        CLS_V_TRANS,
        CLS_VOICED,
        CLS_ONSET
    } frame_class_t;

    typedef enum logic [1:0] {
        generic_full_rate_type,
        voiced_half_rate_type,
        unvoiced_half_rate_type,
        quarter_rate_type
    } enc_type_t;

    typedef struct packed {
        logic [15:0] merit_value;
        logic signed [15:0] relative_frame_energy;
        logic voice_activity_flag;
        enc_type_t enc_type;
    } frame_feat_t;

    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CODE_MAP = 8'h00;
    localparam logic [7:0] ADDR_FEAT_A = 8'h04;
    localparam logic [7:0] ADDR_FEAT_B = 8'h08;
    localparam logic [7:0] ADDR_FRAME = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FIELD = 8'h14;

    // Merit value is unsigned Q1.15, energy is signed Q7.8
    localparam logic [15:0] TH_VOICED_GE = 16'h547b;
    localparam logic [15:0] TH_VTRANS_GE = 16'h3eb9;
    localparam logic [15:0] TH_ONSET_GT = 16'h50a3;
    localparam logic [15:0] TH_UVTRANS_GT = 16'h4ae1;
    localparam logic signed [15:0] REL_ENERGY_MIN = 16'shf800;

    localparam int ENERGY_W = 6;
    localparam int CODE_W = 2;
    localparam int PHASE_W = 6;
    localparam int FIELD_W = 14;
    localparam int FIELD_PHASE_LSB = 0;
    localparam int FIELD_CODE_LSB = 6;
    localparam int FIELD_ENERGY_LSB = 8;

    localparam logic [7:0] CODE_MAP_RST = 8'he4;
    localparam int MAP_UV_LSB = 0;
    localparam int MAP_TR_LSB = 2;
    localparam int MAP_V_LSB = 4;
    localparam int MAP_ON_LSB = 6;

    localparam int FEATB_ENERGY_LSB = 0;
    localparam int FEATB_PHASE_LSB = 8;
    localparam int FEATB_VAD_BIT = 16;
    localparam int STAT_VALID_BIT = 3;
    localparam int STAT_FIELD_LSB = 16;
endpackage
`default_nettype wire

//--- class_decide.sv
// Frame class state machine holding the current and previous frame class
`timescale 1ns/1ps
`default_nettype none
module class_decide
    import fec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic load,
    input wire fec_pkg::frame_feat_t feat,
    output fec_pkg::frame_class_t cls,
    output fec_pkg::frame_class_t prev_cls,
    output fec_pkg::enc_type_t last_type,
    output logic done
);
    import fec_pkg::*;

    frame_class_t next_cls;
    frame_class_t next_prev_cls;
    enc_type_t next_last_type;
    logic next_done;
    logic prev_voiced;

    always_comb
    begin
        next_cls = cls;
        next_prev_cls = prev_cls;
        next_last_type = last_type;
        next_done = 1'b0;
        prev_voiced = (cls == CLS_V_TRANS) || (cls == CLS_VOICED) || (cls == CLS_ONSET);
        if (load)
        begin
            next_prev_cls = cls;
            next_last_type = feat.enc_type;
            next_done = 1'b1;
            case (feat.enc_type)
                voiced_half_rate_type: next_cls = CLS_VOICED;
                unvoiced_half_rate_type: next_cls = CLS_UNVOICED;
                quarter_rate_type: next_cls = CLS_UNVOICED;
                default:
                begin
                    // Merit value already covers the lookahead of the next frame
                    if (!feat.voice_activity_flag || feat.relative_frame_energy < REL_ENERGY_MIN)
                        next_cls = CLS_UNVOICED;
                    else if (prev_voiced)
                    begin
                        if (feat.merit_value >= TH_VOICED_GE)
                            next_cls = CLS_VOICED;
                        else if (feat.merit_value >= TH_VTRANS_GE)
                            next_cls = CLS_V_TRANS;
                        else
                            next_cls = CLS_UNVOICED;
                    end
                    else
                    begin
                        if (feat.merit_value > TH_ONSET_GT)
                            next_cls = CLS_ONSET;
                        else if (feat.merit_value > TH_UVTRANS_GT)
                            next_cls = CLS_UV_TRANS;
                        else
                            next_cls = CLS_UNVOICED;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cls <= CLS_UNVOICED;
            prev_cls <= CLS_UNVOICED;
            last_type <= generic_full_rate_type;
            done <= 1'b0;
        end
        else if (ce)
        begin
            cls <= next_cls;
            prev_cls <= next_prev_cls;
            last_type <= next_last_type;
            done <= next_done;
        end
    end

    AST_UVT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        (done && cls == CLS_UV_TRANS) |-> (prev_cls == CLS_UNVOICED || prev_cls == CLS_UV_TRANS))
        else $error("Unvoiced transition after a voiced class");
    AST_VT_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        (done && cls == CLS_V_TRANS) |-> (prev_cls inside {CLS_V_TRANS, CLS_VOICED, CLS_ONSET}))
        else $error("Voiced transition after an unvoiced class");
    AST_VOICED_ENTRY: assert property (@(posedge pclk) disable iff (!presetn)
        (done && cls == CLS_VOICED && last_type == generic_full_rate_type)
        |-> (prev_cls inside {CLS_V_TRANS, CLS_VOICED, CLS_ONSET}))
        else $error("Voiced class after an unvoiced class");
    AST_ONSET_AFTER_UV: assert property (@(posedge pclk) disable iff (!presetn)
        (load && ce && feat.enc_type == generic_full_rate_type && feat.voice_activity_flag
        && feat.relative_frame_energy >= REL_ENERGY_MIN && feat.merit_value > TH_ONSET_GT
        && (cls == CLS_UNVOICED || cls == CLS_UV_TRANS)) |=> (cls == CLS_ONSET && done))
        else $error("Strong voiced frame after unvoiced not taken as onset");
    AST_FORCE_UNVOICED: assert property (@(posedge pclk) disable iff (!presetn)
        (load && ce && feat.enc_type == generic_full_rate_type
        && (!feat.voice_activity_flag || feat.relative_frame_energy < REL_ENERGY_MIN))
        |=> cls == CLS_UNVOICED)
        else $error("Inactive or quiet frame not forced unvoiced");
    AST_HR_VOICED: assert property (@(posedge pclk) disable iff (!presetn)
        (load && ce && feat.enc_type == voiced_half_rate_type) |=> (cls == CLS_VOICED
        && prev_cls == $past(cls)))
        else $error("Voiced half rate frame not classified voiced");
    AST_EVERY_FRAME: assert property (@(posedge pclk) disable iff (!presetn)
        (load && ce) |=> done)
        else $error("Frame strobe did not update class state");
    COV_ONSET: cover property (@(posedge pclk) disable iff (!presetn) done && cls == CLS_ONSET);
    COV_VTRANS: cover property (@(posedge pclk) disable iff (!presetn)
        done && cls == CLS_V_TRANS);
endmodule
`default_nettype wire

//--- frame_class_fsm.sv
// Frame classifier with supplementary field packing and APB register file
// Summary of operation
// - Every generic full-rate frame yields a 14-bit supplementary field.
// - Field carries a 6-bit quantized energy.
// - Field carries a 6-bit first glottal pulse position.
// - Field carries the class decision as a 2-bit code.
// - Class state takes five values: unvoiced, two transitions, voiced, onset.
// - Unvoiced or inactive frames, noise included, are classed unvoiced.
// - Unvoiced transition only follows unvoiced or unvoiced transition.
// - Voiced transition only follows voiced transition, voiced or onset.
// - Voiced from a generic full-rate frame only follows voiced transition, voiced or onset.
// - Stable voiced frame after an unvoiced class becomes onset.
// - Both transition classes share one 2-bit code.
// - Decision uses lookahead of the next frame via the merit value.
// - No voice activity or relative energy below -8 forces unvoiced.
// - After voiced classes: voiced >=0.66, voiced transition >=0.49, else unvoiced.
// - After unvoiced classes: onset >0.63, unvoiced transition >0.585, else unvoiced.
// - Class updates every frame; half-rate and quarter-rate types are fixed.
`timescale 1ns/1ps
`default_nettype none
module frame_class_fsm
    import fec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fec_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [fec_pkg::FIELD_W-1:0] supp_field,
    output logic supp_valid,
    output fec_pkg::frame_class_t frame_class
);
    import fec_pkg::*;

    logic [7:0] code_map;
    logic [15:0] merit_value;
    logic signed [15:0] relative_frame_energy;
    logic [ENERGY_W-1:0] energy;
    logic [PHASE_W-1:0] first_pulse_position;
    logic voice_activity_flag;
    logic frame_load;
    frame_feat_t frame_feat;
    logic [ENERGY_W-1:0] frame_energy;
    logic [PHASE_W-1:0] frame_phase;
    logic field_held;

    logic [7:0] next_code_map;
    logic [15:0] next_merit_value;
    logic signed [15:0] next_relative_frame_energy;
    logic [ENERGY_W-1:0] next_energy;
    logic [PHASE_W-1:0] next_first_pulse_position;
    logic next_voice_activity_flag;
    logic next_frame_load;
    frame_feat_t next_frame_feat;
    logic [ENERGY_W-1:0] next_frame_energy;
    logic [PHASE_W-1:0] next_frame_phase;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [FIELD_W-1:0] next_supp_field;
    logic next_supp_valid;
    logic next_field_held;

    frame_class_t prev_cls;
    enc_type_t last_type;
    logic done;
    logic access;
    logic [CODE_W-1:0] cur_code;

    class_decide u_decide (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .load(frame_load),
        .feat(frame_feat),
        .cls(frame_class),
        .prev_cls(prev_cls),
        .last_type(last_type),
        .done(done)
    );

    assign access = psel && penable && pready;

    // Class to code translation through the shared map
    always_comb
    begin
        case (frame_class)
            CLS_UNVOICED: cur_code = code_map[MAP_UV_LSB +: CODE_W];
            CLS_UV_TRANS: cur_code = code_map[MAP_TR_LSB +: CODE_W];
            CLS_V_TRANS: cur_code = code_map[MAP_TR_LSB +: CODE_W];
            CLS_VOICED: cur_code = code_map[MAP_V_LSB +: CODE_W];
            default: cur_code = code_map[MAP_ON_LSB +: CODE_W];
        endcase
    end

    // Register writes and frame strobe
    always_comb
    begin
        next_code_map = code_map;
        next_merit_value = merit_value;
        next_relative_frame_energy = relative_frame_energy;
        next_energy = energy;
        next_first_pulse_position = first_pulse_position;
        next_voice_activity_flag = voice_activity_flag;
        next_frame_load = 1'b0;
        next_frame_feat = frame_feat;
        next_frame_energy = frame_energy;
        next_frame_phase = frame_phase;
        if (access && pwrite)
        begin
            if (paddr == ADDR_CODE_MAP)
                next_code_map = pwdata[7:0];
            else if (paddr == ADDR_FEAT_A)
            begin
                next_merit_value = pwdata[15:0];
                next_relative_frame_energy = pwdata[31:16];
            end
            else if (paddr == ADDR_FEAT_B)
            begin
                next_energy = pwdata[FEATB_ENERGY_LSB +: ENERGY_W];
                next_first_pulse_position = pwdata[FEATB_PHASE_LSB +: PHASE_W];
                next_voice_activity_flag = pwdata[FEATB_VAD_BIT];
            end
            else if (paddr == ADDR_FRAME)
            begin
                next_frame_load = 1'b1;
                next_frame_feat.merit_value = merit_value;
                next_frame_feat.relative_frame_energy = relative_frame_energy;
                next_frame_feat.voice_activity_flag = voice_activity_flag;
                next_frame_feat.enc_type = enc_type_t'(pwdata[1:0]);
                next_frame_energy = energy;
                next_frame_phase = first_pulse_position;
            end
        end
    end

    // Supplementary field packing
    always_comb
    begin
        next_supp_field = supp_field;
        next_supp_valid = 1'b0;
        next_field_held = field_held;
        if (done)
        begin
            next_field_held = (last_type == generic_full_rate_type);
            if (last_type == generic_full_rate_type)
            begin
                next_supp_valid = 1'b1;
                next_supp_field[FIELD_ENERGY_LSB +: ENERGY_W] = frame_energy;
                next_supp_field[FIELD_CODE_LSB +: CODE_W] = cur_code;
                next_supp_field[FIELD_PHASE_LSB +: PHASE_W] = frame_phase;
            end
        end
    end

    // APB answer, one wait state
    always_comb
    begin
        next_pready = psel && penable && !pready;
        next_prdata = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (psel && penable && !pready)
        begin
            if (paddr == ADDR_CODE_MAP)
                next_prdata[7:0] = code_map;
            else if (paddr == ADDR_FEAT_A)
                next_prdata = {relative_frame_energy, merit_value};
            else if (paddr == ADDR_FEAT_B)
            begin
                next_prdata[FEATB_ENERGY_LSB +: ENERGY_W] = energy;
                next_prdata[FEATB_PHASE_LSB +: PHASE_W] = first_pulse_position;
                next_prdata[FEATB_VAD_BIT] = voice_activity_flag;
            end
            else if (paddr == ADDR_FRAME)
                next_prdata[1:0] = frame_feat.enc_type;
            else if (paddr == ADDR_STATUS)
            begin
                next_prdata[2:0] = frame_class;
                next_prdata[STAT_VALID_BIT] = field_held;
                next_prdata[STAT_FIELD_LSB +: 3] = prev_cls;
            end
            else if (paddr == ADDR_FIELD)
                next_prdata[FIELD_W-1:0] = supp_field;
            else
                next_pslverr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            code_map <= CODE_MAP_RST;
            merit_value <= 16'h0000;
            relative_frame_energy <= 16'sh0000;
            energy <= '0;
            first_pulse_position <= '0;
            voice_activity_flag <= 1'b0;
            frame_load <= 1'b0;
            frame_feat <= '0;
            frame_energy <= '0;
            frame_phase <= '0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            supp_field <= '0;
            supp_valid <= 1'b0;
            field_held <= 1'b0;
        end
        else if (ce)
        begin
            code_map <= next_code_map;
            merit_value <= next_merit_value;
            relative_frame_energy <= next_relative_frame_energy;
            energy <= next_energy;
            first_pulse_position <= next_first_pulse_position;
            voice_activity_flag <= next_voice_activity_flag;
            frame_load <= next_frame_load;
            frame_feat <= next_frame_feat;
            frame_energy <= next_frame_energy;
            frame_phase <= next_frame_phase;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            supp_field <= next_supp_field;
            supp_valid <= next_supp_valid;
            field_held <= next_field_held;
        end
    end

    AST_FIELD_ONLY_FR: assert property (@(posedge pclk) disable iff (!presetn)
        (done && ce) |=> (supp_valid == (last_type == generic_full_rate_type)))
        else $error("Supplementary field valid does not follow frame type");
    AST_FIELD_CONTENT: assert property (@(posedge pclk) disable iff (!presetn)
        supp_valid |-> (supp_field[FIELD_ENERGY_LSB +: ENERGY_W] == frame_energy
        && supp_field[FIELD_PHASE_LSB +: PHASE_W] == frame_phase))
        else $error("Energy or phase misplaced in supplementary field");
    AST_TRANS_CODE: assert property (@(posedge pclk) disable iff (!presetn)
        (supp_valid && (frame_class == CLS_UV_TRANS || frame_class == CLS_V_TRANS))
        |-> supp_field[FIELD_CODE_LSB +: CODE_W] == code_map[MAP_TR_LSB +: CODE_W])
        else $error("Transition class not sent with shared code");
    AST_RESET_UNVOICED: assert property (@(posedge pclk)
        $rose(presetn) |-> (frame_class == CLS_UNVOICED && !supp_valid))
        else $error("Class state not unvoiced after reset");
    AST_PREADY_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready && ce) |=> pready ##1 !pready)
        else $error("APB answer not after one wait state");
    COV_FIELD: cover property (@(posedge pclk) disable iff (!presetn) supp_valid);
    COV_SLVERR: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
endmodule
`default_nettype wire

//--- fec_decoder_model.sv
// Decoder-side model that resolves the received class code
`timescale 1ns/1ps
`default_nettype none
module fec_decoder_model
    import fec_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] code_map,
    input wire logic [fec_pkg::FIELD_W-1:0] supp_field,
    input wire logic supp_valid,
    input wire logic lost,
    output fec_pkg::frame_class_t dec_cls,
    output logic rebuild
);
    import fec_pkg::*;

    frame_class_t prev;
    logic gap;
    logic [1:0] code;
    assign code = supp_field[FIELD_CODE_LSB +: CODE_W];
    always_comb
    begin
        if (code == code_map[MAP_TR_LSB +: 2])
            dec_cls = (prev == CLS_UNVOICED || prev == CLS_UV_TRANS) ? CLS_UV_TRANS : CLS_V_TRANS;
        else if (code == code_map[MAP_UV_LSB +: 2])
            dec_cls = CLS_UNVOICED;
        else if (code == code_map[MAP_V_LSB +: 2])
            dec_cls = CLS_VOICED;
        else
            dec_cls = CLS_ONSET;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev <= CLS_UNVOICED;
            gap <= 1'b0;
            rebuild <= 1'b0;
        end
        else if (supp_valid && ce)
        begin
            // Lost frame keeps the last good class as reference
            gap <= lost;
            rebuild <= gap && !lost && prev == CLS_UNVOICED && dec_cls == CLS_VOICED;
            if (!lost)
                prev <= dec_cls;
        end
    end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the frame classifier
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fec_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, supp_valid, dec_ok;
    logic lost, rebuild;
    logic [7:0] paddr, map;
    logic [31:0] pwdata, prdata, r;
    logic [FIELD_W-1:0] supp_field;
    frame_class_t frame_class, dec_cls, prev;
    int n_fail = 0, n_tests = 0, seed = 32'h20d9, i, j;
    logic [31:0] rq_d[$], rq_m[$];
    logic rq_e[$], fq_o[$];
    logic [FIELD_W-1:0] fq_f[$];
    frame_class_t fq_c[$];
    logic [7:0] maps[2] = '{8'h1b, 8'h4e};

    frame_class_fsm frame_class_fsm_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .supp_field(supp_field),
        .supp_valid(supp_valid), .frame_class(frame_class));
    fec_decoder_model fec_decoder_model_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
        .code_map(map), .supp_field(supp_field), .supp_valid(supp_valid), .lost(lost),
        .dec_cls(dec_cls), .rebuild(rebuild));

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task finish_test;
        $display("Tests %0d, failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic frame_class_t exp_class(frame_class_t p, enc_type_t t, logic [15:0] m,
        logic signed [15:0] e, logic v);
        if (t == voiced_half_rate_type) return CLS_VOICED;
        if (t != generic_full_rate_type) return CLS_UNVOICED;
        if (!v || e < REL_ENERGY_MIN) return CLS_UNVOICED;
        if (p == CLS_ONSET || p == CLS_VOICED || p == CLS_V_TRANS)
            return m >= TH_VOICED_GE ? CLS_VOICED : m >= TH_VTRANS_GE ? CLS_V_TRANS : CLS_UNVOICED;
        return m > TH_ONSET_GT ? CLS_ONSET : m > TH_UVTRANS_GT ? CLS_UV_TRANS : CLS_UNVOICED;
    endfunction

    function automatic logic [1:0] code_of(frame_class_t c);
        case (c)
            CLS_UNVOICED: return map[MAP_UV_LSB +: 2];
            CLS_VOICED: return map[MAP_V_LSB +: 2];
            CLS_ONSET: return map[MAP_ON_LSB +: 2];
            default: return map[MAP_TR_LSB +: 2];
        endcase
    endfunction

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        input logic [31:0] ed, input logic [31:0] em, input logic ee);
        if (!w)
        begin
            rq_d.push_back(ed);
            rq_m.push_back(em);
            rq_e.push_back(ee);
        end
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!(pready === 1'b1 && ce === 1'b1))
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic frame(input logic [15:0] m, input logic [15:0] e, input logic v,
        input enc_type_t t);
        logic [5:0] en, ph;
        logic fr;
        frame_class_t c;
        {en, ph} = 12'($random(seed));
        c = exp_class(prev, t, m, e, v);
        wr(ADDR_FEAT_A, {e, m});
        wr(ADDR_FEAT_B, {15'h0000, v, 2'b00, ph, 2'b00, en});
        if (t == generic_full_rate_type)
        begin
            fq_f.push_back({en, code_of(c), ph});
            fq_c.push_back(c);
            fq_o.push_back(dec_ok);
        end
        wr(ADDR_FRAME, {30'h0000_0000, t});
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        fr = (t == generic_full_rate_type);
        // Decoder reference stays right only after a received full-rate frame it resolved
        dec_ok = fr && !lost && (dec_ok || !(c inside {CLS_UV_TRANS, CLS_V_TRANS}));
        prev = c;
        apb(ADDR_STATUS, 1'b0, 0, {28'h000_0000, fr, c}, 32'h0000_000f, 1'b0);
        if (fr)
            apb(ADDR_FIELD, 1'b0, 0, 32'({en, code_of(c), ph}), 32'h0000_3fff, 1'b0);
        apb(ADDR_FRAME, 1'b0, 0, {30'h0000_0000, t}, 32'h0000_0003, 1'b0);
    endtask

    always @(posedge pclk)
    begin
        logic [31:0] ed, em;
        logic ee, o;
        logic [FIELD_W-1:0] f;
        frame_class_t c;
        if (presetn && ce === 1'b1 && pready === 1'b1 && psel && penable && !pwrite)
        begin
            ed = rq_d.pop_front();
            em = rq_m.pop_front();
            ee = rq_e.pop_front();
            check((prdata & em) === (ed & em) && pslverr === ee, "read answer");
        end
        if (presetn && ce === 1'b1 && supp_valid === 1'b1)
        begin
            if (fq_f.size() == 0)
                check(1'b0, "field without full-rate frame");
            else
            begin
                f = fq_f.pop_front();
                c = fq_c.pop_front();
                o = fq_o.pop_front();
                check(supp_field === f, "supplementary field");
                check(frame_class === c, "frame class");
                if (o)
                    check(dec_cls === c, "decoder resolution");
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        finish_test;
    end

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        map = CODE_MAP_RST;
        prev = CLS_UNVOICED;
        dec_ok = 1'b1;
        lost = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(ADDR_STATUS, 1'b0, 0, 32'h0000_0000, 32'h0007_000f, 1'b0);
        apb(ADDR_CODE_MAP, 1'b0, 0, {24'h00_0000, CODE_MAP_RST}, 32'h0000_00ff, 1'b0);
        apb(8'h20, 1'b0, 0, 32'h0000_0000, 32'hffff_ffff, 1'b1);
        wr(8'h20, 32'hffff_ffff);
        frame(16'h4ae1, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h4ae2, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h50a3, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h50a4, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h547b, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h547a, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h3eb9, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h3eb8, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h0000, 16'h0000, 1'b1, voiced_half_rate_type);
        frame(16'h7fff, 16'hf7ff, 1'b1, generic_full_rate_type);
        frame(16'h7fff, 16'hf800, 1'b0, generic_full_rate_type);
        frame(16'h7fff, 16'hf800, 1'b1, generic_full_rate_type);
        frame(16'h7fff, 16'h0000, 1'b1, generic_full_rate_type);
        frame(16'h7fff, 16'h0000, 1'b1, unvoiced_half_rate_type);
        frame(16'h7fff, 16'h0000, 1'b1, quarter_rate_type);
        frame(16'h0000, 16'h0000, 1'b1, generic_full_rate_type);
        lost <= 1'b1;
        frame(16'h7fff, 16'h0000, 1'b1, generic_full_rate_type);
        lost <= 1'b0;
        frame(16'h7fff, 16'h0000, 1'b1, generic_full_rate_type);
        check(rebuild === 1'b1, "lost onset not rebuilt");
        frame(16'h0000, 16'h0000, 1'b1, generic_full_rate_type);
        lost <= 1'b1;
        frame(16'h0000, 16'h0000, 1'b1, generic_full_rate_type);
        lost <= 1'b0;
        frame(16'h7fff, 16'h0000, 1'b1, generic_full_rate_type);
        check(rebuild === 1'b0, "rebuild after a received onset");
        wr(ADDR_STATUS, 32'hffff_ffff);
        wr(ADDR_FIELD, 32'hffff_ffff);
        apb(ADDR_STATUS, 1'b0, 0, {28'h000_0000, 1'b1, prev}, 32'h0000_000f, 1'b0);
        apb(ADDR_FEAT_A, 1'b0, 0, 32'h0000_7fff, 32'hffff_ffff, 1'b0);
        apb(ADDR_FEAT_B, 1'b0, 0, 32'h0001_0000, 32'h0001_0000, 1'b0);
        for (j = 0; j < 2; j++)
        begin
            map = maps[j];
            wr(ADDR_CODE_MAP, {24'h00_0000, map});
            apb(ADDR_CODE_MAP, 1'b0, 0, {24'h00_0000, map}, 32'h0000_00ff, 1'b0);
            for (i = 0; i < 30; i++)
            begin
                r = $random(seed);
                frame({1'b0, r[31:17]}, {{3{r[12]}}, r[12:0]}, r[13] | r[14],
                    r[15] ? generic_full_rate_type : enc_type_t'(r[16:15]));
            end
        end
        repeat (10) @(posedge pclk);
        check(fq_f.size() == 0, "missing supplementary field");
        finish_test;
    end
endmodule
`default_nettype wire
